//--- rtl/dcff_pkg.sv
package dcff_pkg;
  localparam int DW = 18; // word width
  localparam int AW = 13; // memory address width
  localparam int DEPTH = 8192; // memory words
  localparam logic [AW:0] DEPTH_C = 14'h2000; // depth as a count
  localparam logic [AW:0] HALF_C = 14'h1000; // half depth
  localparam logic [AW-1:0] OFS_PAR = 13'h007F; // parallel default
  localparam logic [AW-1:0] OFS_SER = 13'h03FF; // serial default
  localparam logic [1:0] HOLD_CYC = 2'h3; // flag round-trip wait
  // controller register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OFS = 8'h04;
  localparam logic [7:0] A_TX = 8'h08;
  localparam logic [7:0] A_RX = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_INT = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;
  // control field positions
  localparam int C_MODE = 0;
  localparam int C_LD = 1;
  localparam int C_MRST = 2;
  localparam int C_POP = 3;
  localparam int OFS_FULL_LSB = 16; // full offset field in A_OFS
  // interrupt bit positions
  localparam int I_AVAIL = 0;
  localparam int I_FULL = 1;
  localparam int I_HALF = 2;
  localparam int I_OVR = 3;
  localparam int NI = 4;

  // binary to gray
  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  // gray to binary
  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction
endpackage

//--- rtl/dcff_if.sv
// link between the buffer and its writer/reader controller
interface dcff_if;
  import dcff_pkg::*;
  logic mode_select_serial_in; // strap: 0 standard, 1 fall-through
  logic offset_load_select; // strap: 0 parallel, 1 serial defaults
  logic master_reset; // synchronous master reset pulse
  logic offset_wr; // load both offsets
  logic [AW-1:0] empty_offset;
  logic [AW-1:0] full_offset;
  logic write_en_n;
  logic [DW-1:0] data_in;
  logic read_en_n;
  logic [DW-1:0] data_out;
  logic empty_flag_n;
  logic output_ready_n;
  logic full_flag_n;
  logic input_ready_n;
  logic almost_empty_n;
  logic almost_full_n;
  logic half_full_n;

  modport dev (
    input mode_select_serial_in, offset_load_select, master_reset,
    input offset_wr, empty_offset, full_offset,
    input write_en_n, data_in, read_en_n,
    output data_out, empty_flag_n, output_ready_n, full_flag_n,
    output input_ready_n, almost_empty_n, almost_full_n, half_full_n
  );
  modport host (
    output mode_select_serial_in, offset_load_select, master_reset,
    output offset_wr, empty_offset, full_offset,
    output write_en_n, data_in, read_en_n,
    input data_out, empty_flag_n, output_ready_n, full_flag_n,
    input input_ready_n, almost_empty_n, almost_full_n, half_full_n
  );
endinterface

//--- rtl/dcff_device.sv
// buffer end: memory, pointers, flag generation
module dcff_device
  import dcff_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to the controller
  dcff_if.dev link
);
  logic [DW-1:0] mem [0:DEPTH-1]; // storage, no reset
  logic init_ff; // strap capture pending
  logic fall_through_mode_ff; // latched timing mode
  logic [AW-1:0] eofs_ff; // empty offset n
  logic [AW-1:0] fofs_ff; // full offset m
  logic [AW:0] wbin_ff; // write pointer, extra wrap bit
  logic [AW:0] rbin_ff; // read pointer, extra wrap bit
  logic [AW:0] wgray_ff; // gray copies sent across
  logic [AW:0] rgray_ff;
  logic [AW:0] wg_s1_ff; // write pointer into read side
  logic [AW:0] wg_s2_ff;
  logic [AW:0] rg_s1_ff; // read pointer into write side
  logic [AW:0] rg_s2_ff;
  logic [AW:0] wcnt; // count seen by the write side
  logic [AW:0] rcnt; // count seen by the read side
  logic full_int; // memory full, undelayed
  logic empty_int; // memory empty, undelayed
  logic wr_go; // word accepted this cycle
  logic mem_rd; // memory word moved to output
  logic valid_ff; // fall-through output register holds a word
  logic nxt_valid;
  logic full_s1_ff; // first flag stage, write side
  logic nempty_s1_ff; // first flag stage, read side
  logic [DW-1:0] data_out_ff;
  logic empty_flag_n_ff;
  logic output_ready_n_ff;
  logic full_flag_n_ff;
  logic input_ready_n_ff;
  logic almost_empty_n_ff;
  logic almost_full_n_ff;
  logic half_full_n_ff;

  // counts: the far pointer is older, so full and empty err safe
  assign wcnt = wbin_ff - gray2bin(rg_s2_ff);
  assign rcnt = gray2bin(wg_s2_ff) - rbin_ff;
  assign full_int = (wcnt == DEPTH_C);
  assign empty_int = (rcnt == '0);
  assign wr_go = !link.write_en_n && !full_int && !link.master_reset;

  // output register refill in fall-through, explicit read otherwise
  always_comb begin
    mem_rd = 1'b0;
    nxt_valid = valid_ff;
    if (fall_through_mode_ff) begin
      // refill when vacant or when the held word is taken
      if (!empty_int && (!valid_ff || !link.read_en_n)) begin
        mem_rd = 1'b1;
        nxt_valid = 1'b1;
      end else if (!link.read_en_n) begin
        nxt_valid = 1'b0;
      end
    end else begin
      // standard: read only on request and never from empty
      mem_rd = !link.read_en_n && !empty_int;
    end
    if (link.master_reset) begin
      mem_rd = 1'b0;
      nxt_valid = 1'b0;
    end
  end

  // strap capture one cycle after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_ff <= 1'b1;
      fall_through_mode_ff <= 1'b0;
      eofs_ff <= OFS_PAR;
      fofs_ff <= OFS_PAR;
    end else if (link.master_reset) begin
      init_ff <= 1'b1; // re-latch straps after soft reset
    end else if (init_ff) begin
      init_ff <= 1'b0;
      fall_through_mode_ff <= link.mode_select_serial_in;
      // default offsets follow the load-method strap
      eofs_ff <= link.offset_load_select ? OFS_SER : OFS_PAR;
      fofs_ff <= link.offset_load_select ? OFS_SER : OFS_PAR;
    end else if (link.offset_wr) begin
      eofs_ff <= link.empty_offset;
      fofs_ff <= link.full_offset;
    end
  end

  // memory write, no reset on the array
  always_ff @(posedge mclk) begin
    if (wr_go) begin
      mem[wbin_ff[AW-1:0]] <= link.data_in;
    end
  end

  // write pointer and its gray copy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end else if (link.master_reset) begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end else if (wr_go) begin
      wbin_ff <= wbin_ff + 1'b1;
      wgray_ff <= bin2gray(wbin_ff + 1'b1);
    end
  end

  // read pointer and its gray copy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rbin_ff <= '0;
      rgray_ff <= '0;
    end else if (link.master_reset) begin
      rbin_ff <= '0;
      rgray_ff <= '0;
    end else if (mem_rd) begin
      rbin_ff <= rbin_ff + 1'b1;
      rgray_ff <= bin2gray(rbin_ff + 1'b1);
    end
  end

  // two-stage pointer crossings; gray keeps a torn sample to +-1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wg_s1_ff <= '0;
      wg_s2_ff <= '0;
      rg_s1_ff <= '0;
      rg_s2_ff <= '0;
    end else if (link.master_reset) begin
      wg_s1_ff <= '0;
      wg_s2_ff <= '0;
      rg_s1_ff <= '0;
      rg_s2_ff <= '0;
    end else begin
      wg_s1_ff <= wgray_ff;
      wg_s2_ff <= wg_s1_ff;
      rg_s1_ff <= rgray_ff;
      rg_s2_ff <= rg_s1_ff;
    end
  end

  // output data register and fall-through valid bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      if (mem_rd) begin
        data_out_ff <= mem[rbin_ff[AW-1:0]];
      end
    end
  end

  // write-side flags: full/input ready through two stages
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      full_s1_ff <= 1'b0;
      full_flag_n_ff <= 1'b1;
      input_ready_n_ff <= 1'b1;
      half_full_n_ff <= 1'b1;
      almost_full_n_ff <= 1'b1;
    end else if (link.master_reset || init_ff) begin
      full_s1_ff <= 1'b0;
      full_flag_n_ff <= 1'b1;
      input_ready_n_ff <= 1'b1;
      half_full_n_ff <= 1'b1;
      almost_full_n_ff <= 1'b1;
    end else begin
      full_s1_ff <= full_int;
      // the pin serves as full in standard, input ready otherwise
      full_flag_n_ff <= fall_through_mode_ff ? 1'b1 : !full_s1_ff;
      input_ready_n_ff <= fall_through_mode_ff ? full_s1_ff : 1'b1;
      // memory count; in fall-through the output word adds one,
      // which shifts every printed threshold by exactly one
      half_full_n_ff <= !(wcnt > HALF_C);
      almost_full_n_ff <= !(wcnt >= (DEPTH_C - {1'b0, fofs_ff}));
    end
  end

  // read-side flags: empty through two stages
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nempty_s1_ff <= 1'b0;
      empty_flag_n_ff <= 1'b0;
      output_ready_n_ff <= 1'b1;
      almost_empty_n_ff <= 1'b0;
    end else if (link.master_reset || init_ff) begin
      nempty_s1_ff <= 1'b0;
      empty_flag_n_ff <= 1'b0;
      output_ready_n_ff <= 1'b1;
      almost_empty_n_ff <= 1'b0;
    end else begin
      nempty_s1_ff <= !empty_int;
      empty_flag_n_ff <= fall_through_mode_ff ? 1'b0 : nempty_s1_ff;
      // pointer sync (two) plus this stage: three edges
      output_ready_n_ff <= fall_through_mode_ff ? !nxt_valid : 1'b1;
      almost_empty_n_ff <= (rcnt > {1'b0, eofs_ff});
    end
  end

  // drive the link
  assign link.data_out = data_out_ff;
  assign link.empty_flag_n = empty_flag_n_ff;
  assign link.output_ready_n = output_ready_n_ff;
  assign link.full_flag_n = full_flag_n_ff;
  assign link.input_ready_n = input_ready_n_ff;
  assign link.almost_empty_n = almost_empty_n_ff;
  assign link.almost_full_n = almost_full_n_ff;
  assign link.half_full_n = half_full_n_ff;
endmodule

//--- rtl/dcff_host.sv
// controller end: software registers drive writer and reader
module dcff_host
  import dcff_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // link to the buffer
  dcff_if.host link
);
  logic [1:0] ctrl_ff; // mode strap, load-method strap
  logic mrst_ff; // master reset pulse
  logic ofs_wr_ff; // offset load pulse
  logic [AW-1:0] eofs_ff;
  logic [AW-1:0] fofs_ff;
  logic [DW-1:0] tx_data_ff; // word waiting to be written
  logic tx_pend_ff;
  logic pop_pend_ff;
  logic write_en_n_ff;
  logic read_en_n_ff;
  logic [DW-1:0] data_in_ff;
  logic [1:0] wr_hold_ff; // waits out the flag pipeline
  logic [1:0] rd_hold_ff;
  logic space; // buffer shows room
  logic avail; // buffer shows data
  logic space_d_ff;
  logic avail_d_ff;
  logic hf_d_ff;
  logic wr_issue;
  logic rd_issue;
  logic [NI-1:0] ev; // event pulses
  logic [NI-1:0] int_stat_ff;
  logic [NI-1:0] int_mask_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // the flag pins change meaning with the mode
  assign space = ctrl_ff[C_MODE] ? !link.input_ready_n : link.full_flag_n;
  assign avail = ctrl_ff[C_MODE] ? !link.output_ready_n
                                 : link.empty_flag_n;
  assign wr_issue = tx_pend_ff && space && (wr_hold_ff == '0)
                    && !mrst_ff;
  assign rd_issue = pop_pend_ff && avail && (rd_hold_ff == '0)
                    && !mrst_ff;

  // control, straps and offsets
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 2'h0;
      mrst_ff <= 1'b0;
      ofs_wr_ff <= 1'b0;
      eofs_ff <= OFS_PAR;
      fofs_ff <= OFS_PAR;
    end else begin
      mrst_ff <= 1'b0;
      ofs_wr_ff <= 1'b0;
      if (reg_wr && reg_addr == A_CTRL) begin
        // straps stay steady across the master reset pulse
        ctrl_ff <= reg_wdata[C_LD:C_MODE];
        mrst_ff <= reg_wdata[C_MRST];
      end else if (reg_wr && reg_addr == A_OFS) begin
        eofs_ff <= reg_wdata[AW-1:0];
        fofs_ff <= reg_wdata[OFS_FULL_LSB+AW-1:OFS_FULL_LSB];
        ofs_wr_ff <= 1'b1;
      end
    end
  end

  // writer: one pending word, sent when the flags show room
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_data_ff <= '0;
      tx_pend_ff <= 1'b0;
      write_en_n_ff <= 1'b1;
      data_in_ff <= '0;
      wr_hold_ff <= 2'h0;
    end else begin
      write_en_n_ff <= !wr_issue;
      if (wr_issue) begin
        data_in_ff <= tx_data_ff;
        wr_hold_ff <= HOLD_CYC;
      end else if (wr_hold_ff != '0) begin
        wr_hold_ff <= wr_hold_ff - 2'h1;
      end
      // a new word wins over the send of the old one
      if (reg_wr && reg_addr == A_TX) begin
        tx_data_ff <= reg_wdata[DW-1:0];
        tx_pend_ff <= 1'b1;
      end else if (wr_issue || mrst_ff) begin
        tx_pend_ff <= 1'b0;
      end
    end
  end

  // reader: one pop request, sent when the flags show data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pop_pend_ff <= 1'b0;
      read_en_n_ff <= 1'b1;
      rd_hold_ff <= 2'h0;
    end else begin
      read_en_n_ff <= !rd_issue;
      if (rd_issue) begin
        rd_hold_ff <= HOLD_CYC;
      end else if (rd_hold_ff != '0) begin
        rd_hold_ff <= rd_hold_ff - 2'h1;
      end
      if (reg_wr && reg_addr == A_CTRL && reg_wdata[C_POP]) begin
        pop_pend_ff <= 1'b1;
      end else if (rd_issue || mrst_ff) begin
        pop_pend_ff <= 1'b0;
      end
    end
  end

  // event edges from the flag levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      space_d_ff <= 1'b1;
      avail_d_ff <= 1'b0;
      hf_d_ff <= 1'b1;
    end else begin
      space_d_ff <= space;
      avail_d_ff <= avail;
      hf_d_ff <= link.half_full_n;
    end
  end

  always_comb begin
    ev = '0;
    ev[I_AVAIL] = avail && !avail_d_ff;
    ev[I_FULL] = !space && space_d_ff;
    ev[I_HALF] = !link.half_full_n && hf_d_ff;
    ev[I_OVR] = reg_wr && reg_addr == A_TX && tx_pend_ff && !wr_issue;
  end

  // sticky status, write one to clear; a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_stat_ff <= '0;
      int_mask_ff <= '0;
    end else begin
      if (reg_wr && reg_addr == A_INT) begin
        int_stat_ff <= (int_stat_ff & ~reg_wdata[NI-1:0]) | ev;
      end else begin
        int_stat_ff <= int_stat_ff | ev;
      end
      if (reg_wr && reg_addr == A_MASK) begin
        int_mask_ff <= reg_wdata[NI-1:0];
      end
    end
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr == A_CTRL) begin
      nxt_rdata[C_LD:C_MODE] = ctrl_ff;
    end else if (reg_addr == A_OFS) begin
      nxt_rdata[AW-1:0] = eofs_ff;
      nxt_rdata[OFS_FULL_LSB+AW-1:OFS_FULL_LSB] = fofs_ff;
    end else if (reg_addr == A_RX) begin
      nxt_rdata[DW-1:0] = link.data_out;
    end else if (reg_addr == A_STAT) begin
      nxt_rdata[8:0] = {pop_pend_ff, tx_pend_ff, link.half_full_n,
                        link.almost_full_n, link.almost_empty_n,
                        link.input_ready_n, link.full_flag_n,
                        link.output_ready_n, link.empty_flag_n};
    end else if (reg_addr == A_INT) begin
      nxt_rdata[NI-1:0] = int_stat_ff;
    end else if (reg_addr == A_MASK) begin
      nxt_rdata[NI-1:0] = int_mask_ff;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = |(int_stat_ff & int_mask_ff);
  assign link.mode_select_serial_in = ctrl_ff[C_MODE];
  assign link.offset_load_select = ctrl_ff[C_LD];
  assign link.master_reset = mrst_ff;
  assign link.offset_wr = ofs_wr_ff;
  assign link.empty_offset = eofs_ff;
  assign link.full_offset = fofs_ff;
  assign link.write_en_n = write_en_n_ff;
  assign link.data_in = data_in_ff;
  assign link.read_en_n = read_en_n_ff;
endmodule

//--- tb/dcff_assertions.sv
// flag and transfer checks on the buffer/controller link
module dcff_assertions
  import dcff_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // straps and offsets
  input wire logic mode_select_serial_in,
  input wire logic offset_load_select,
  input wire logic master_reset,
  input wire logic offset_wr,
  input wire logic [AW-1:0] empty_offset,
  input wire logic [AW-1:0] full_offset,
  // transfers
  input wire logic write_en_n,
  input wire logic read_en_n,
  input wire logic [DW-1:0] data_out,
  // flags
  input wire logic empty_flag_n,
  input wire logic output_ready_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_n,
  input wire logic almost_full_n,
  input wire logic half_full_n
);
  logic init_ff; // init cycle after any reset
  logic mode_ff; // latched timing mode
  logic [AW-1:0] n_ff; // empty offset in force
  logic [AW-1:0] m_ff; // full offset in force
  logic [AW:0] cnt_ff; // reference word count, standard mode
  logic [3:0] age_ff; // cycles since last link activity
  logic std_q; // standard mode, flags past their sync delay
  logic busy; // any activity this cycle other than a read

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // straps and default offsets latch one edge after a reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_ff <= 1'b1;
      mode_ff <= 1'b0;
      n_ff <= OFS_PAR;
      m_ff <= OFS_PAR;
    end else if (master_reset) begin
      init_ff <= 1'b1;
    end else if (init_ff) begin
      init_ff <= 1'b0;
      mode_ff <= mode_select_serial_in;
      n_ff <= offset_load_select ? OFS_SER : OFS_PAR;
      m_ff <= offset_load_select ? OFS_SER : OFS_PAR;
    end else if (offset_wr) begin
      n_ff <= empty_offset;
      m_ff <= full_offset;
    end
  end

  // writes stop at depth, reads stop at zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (master_reset || init_ff) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + (AW+1)'(!write_en_n && cnt_ff != DEPTH_C)
        - (AW+1)'(!read_en_n && cnt_ff != '0);
    end
  end

  // flags lag the count through the pointer syncs, so judge them late
  assign busy = master_reset || init_ff || offset_wr || !write_en_n;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      age_ff <= '0;
    end else if (busy || !read_en_n) begin
      age_ff <= '0;
    end else if (age_ff != 4'hF) begin
      age_ff <= age_ff + 4'h1;
    end
  end
  assign std_q = !mode_ff && !init_ff && !master_reset && age_ff >= 4'h6;

  reset_flags_a: assert property (
    master_reset |=> !empty_flag_n && !almost_empty_n && half_full_n
      && almost_full_n && full_flag_n)
    else $error("flags not at reset values");
  empty_hold_a: assert property (
    std_q && !write_en_n && cnt_ff == '0 |=> (!empty_flag_n) [*2])
    else $error("empty flag skipped a register stage");
  empty_rise_a: assert property (
    std_q && !write_en_n && cnt_ff == '0 |-> ##[3:6] empty_flag_n)
    else $error("empty flag did not rise after first write");
  empty_level_a: assert property (
    std_q |-> empty_flag_n == (cnt_ff != '0))
    else $error("empty flag disagrees with count");
  full_level_a: assert property (
    std_q |-> full_flag_n == (cnt_ff != DEPTH_C))
    else $error("full flag disagrees with count");
  half_full_a: assert property (
    std_q |-> half_full_n == (cnt_ff <= HALF_C))
    else $error("half-full flag disagrees with count");
  almost_empty_a: assert property (
    std_q |-> almost_empty_n == (cnt_ff > {1'b0, n_ff}))
    else $error("almost-empty flag disagrees with count");
  almost_full_a: assert property (
    std_q |-> almost_full_n == (cnt_ff < DEPTH_C - {1'b0, m_ff}))
    else $error("almost-full flag disagrees with count");
  full_hold_a: assert property (
    !mode_ff && !full_flag_n && read_en_n && !master_reset
      && age_ff >= 4'h4 |=> !full_flag_n)
    else $error("full flag released without a read");
  empty_read_a: assert property (
    std_q && cnt_ff == '0 && !read_en_n |=> $stable(data_out))
    else $error("read from empty buffer changed data");
  std_data_a: assert property (
    !mode_ff && !init_ff && read_en_n |=> $stable(data_out))
    else $error("data changed without a read request");
  first_word_a: assert property (
    mode_ff && !init_ff && age_ff >= 4'h6 && output_ready_n && !write_en_n
      |-> output_ready_n [*3] ##[1:2] !output_ready_n)
    else $error("first word fall-through latency wrong");
endmodule

//--- tb/dual_clock_flag_fifo_test.sv
`define CHECK_EQ(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value at %0t: got %h want %h", $time, got, exp); \
    end \
  end

// drives the controller registers; both link ends are design code
module dual_clock_flag_fifo_test
  import dcff_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // flag checkpoints while filling with serial default offsets
  localparam int CP [8] = '{1023, 1024, 4096, 4097, 7168, 7169, 8191, 8192};
  localparam logic [8:0] EX [8] = '{9'h06F, 9'h07F, 9'h07F, 9'h03F,
    9'h03F, 9'h01F, 9'h01F, 9'h01B};
  logic mclk; // 10 MHz
  logic rst; // async, active high
  logic [7:0] reg_addr; // register port
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic irq;
  logic [31:0] ctrl; // mode and load bits kept across pops
  int fails; // mismatches
  int tests_run; // comparisons
  int cycles; // hang guard

  dcff_if link_if ();
  dcff_device dcff_device_inst (.mclk(mclk), .rst(rst), .link(link_if));
  dcff_host dcff_host_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .link(link_if));
  dcff_assertions dcff_assertions_inst (.mclk(mclk), .rst(rst),
    .mode_select_serial_in(link_if.mode_select_serial_in),
    .offset_load_select(link_if.offset_load_select),
    .master_reset(link_if.master_reset), .offset_wr(link_if.offset_wr),
    .empty_offset(link_if.empty_offset), .full_offset(link_if.full_offset),
    .write_en_n(link_if.write_en_n), .read_en_n(link_if.read_en_n),
    .data_out(link_if.data_out), .empty_flag_n(link_if.empty_flag_n),
    .output_ready_n(link_if.output_ready_n),
    .full_flag_n(link_if.full_flag_n),
    .almost_empty_n(link_if.almost_empty_n),
    .almost_full_n(link_if.almost_full_n),
    .half_full_n(link_if.half_full_n));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // one-cycle register write
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_expect(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHECK_EQ(reg_rdata, e)
  endtask

  // word pattern, distinct per index
  function automatic logic [17:0] word(input int i);
    word = 18'(i) ^ 18'h2AAAA;
  endfunction

  // host needs spacing between link requests, so wait after each
  task automatic push(input int i);
    reg_write(A_TX, {14'h0, word(i)});
    repeat (5) @(posedge mclk);
  endtask
  task automatic pop();
    reg_write(A_CTRL, ctrl | 32'h8);
    repeat (5) @(posedge mclk);
  endtask
  // flags need several edges to cross the pointer syncs
  task automatic settle();
    repeat (12) @(posedge mclk);
  endtask
  task automatic mreset(input logic [31:0] c);
    ctrl = c;
    reg_write(A_CTRL, c | 32'h4);
    settle();
  endtask

  task automatic test_reset();
    reg_expect(A_STAT, 32'h6E);
    reg_expect(A_RX, 32'h0);
    reg_expect(8'h1C, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_small();
    mreset(32'h0);
    reg_write(A_OFS, 32'h0064_0002);
    push(0);
    settle();
    reg_expect(A_STAT, 32'h6F);
    reg_expect(A_RX, 32'h0);
    push(1);
    push(2);
    settle();
    reg_expect(A_STAT, 32'h7F);
    pop();
    settle();
    reg_expect(A_RX, {14'h0, word(0)});
    reg_expect(A_STAT, 32'h6F);
    pop();
    pop();
    settle();
    reg_expect(A_RX, {14'h0, word(2)});
    reg_expect(A_STAT, 32'h6E);
    pop();
    settle();
    reg_expect(A_RX, {14'h0, word(2)});
    $display("test small done");
  endtask

  task automatic test_fill();
    mreset(32'h2);
    reg_write(A_INT, 32'hF);
    for (int i = 0; i < 8192; i++) begin
      push(i);
      for (int k = 0; k < 8; k++) begin
        if (i + 1 == CP[k]) begin
          settle();
          reg_expect(A_STAT, {23'h0, EX[k]});
        end
      end
    end
    reg_expect(A_INT, 32'h7);
    pop();
    settle();
    reg_expect(A_RX, {14'h0, word(0)});
    reg_expect(A_STAT, 32'h1F);
    push(8192);
    settle();
    reg_expect(A_STAT, 32'h1B);
    push(8193);
    settle();
    reg_expect(A_STAT, 32'h9B);
    $display("test fill done");
  endtask

  task automatic test_fall_through();
    mreset(32'h1);
    reg_expect(A_STAT, 32'h66);
    push(5);
    settle();
    reg_expect(A_RX, {14'h0, word(5)});
    reg_expect(A_STAT, 32'h64);
    push(6);
    settle();
    reg_expect(A_RX, {14'h0, word(5)});
    pop();
    settle();
    reg_expect(A_RX, {14'h0, word(6)});
    pop();
    settle();
    reg_expect(A_STAT, 32'h66);
    $display("test fall-through done");
  endtask

  task automatic test_irq();
    mreset(32'h0);
    reg_write(A_INT, 32'hF);
    reg_write(A_MASK, 32'h0);
    push(9);
    settle();
    reg_expect(A_INT, 32'h1);
    #1 `CHECK_EQ(irq, 1'b0)
    reg_write(A_MASK, 32'h1);
    #1 `CHECK_EQ(irq, 1'b1)
    reg_expect(A_MASK, 32'h1);
    reg_write(A_INT, 32'h1);
    #1 `CHECK_EQ(irq, 1'b0)
    // the first word goes out at once; the third lands in its hold time
    reg_write(A_TX, 32'h1);
    reg_write(A_TX, 32'h2);
    reg_write(A_TX, 32'h3);
    settle();
    reg_expect(A_INT, 32'h8);
    $display("test interrupt done");
  endtask

  // single place where the run ends
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      $display("wrong value at %0t: run too long", $time);
      results();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctrl = 32'h0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    test_reset();
    test_small();
    test_fill();
    test_fall_through();
    test_irq();
    results();
  end
endmodule
